// ===== rtl/lhc_dev.sv
/*
 Link host control register bank: control set/clear pair and self-ID base.
 Assumes the host holds a request until ack, and that the PHY clock state
 arrives as an asynchronous pin level.
*/
// The implementer's own choice: the AHB-Lite slave port.
// Notes on behaviour
// RULE1: Enhancements set only with permit and link on
// RULE2: Without permit, enhancement bit stays unchanged
// RULE3: Reserved control bits 21:20 read zero
// RULE4: Power status bit gates link to PHY
// RULE5: Stopped PHY clock domain access is aborted
// RULE6: No-abort option returns all ones instead
// RULE7: DCh-F0h and 100h-11Ch are PHY domain
// RULE8: Software waits 10 ms after power status
// RULE9: Posted write bit changes only while link off
// RULE10: Link enable cleared by either reset
// RULE11: Software enables link then forces bus reset
// RULE12: Link off disconnects from bus at once
// RULE13: Software reset restores link registers
// RULE14: Software reset bit self-clears when done
// RULE15: Low sixteen control bits read zero
// RULE16: Permit bit cleared only by global reset
// RULE17: Self-ID base is 2K aligned address
// RULE18: Self-ID base bits 10:0 read zero
// RULE19: Control reached at set 50h, clear 54h
// RULE20: Ones set or clear, reads show value
`timescale 1ns/1ns
module lhc_dev
  import lhc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  lhc_if.dev               bus,
  input  wire logic        i_phy_clk_live,
  input  wire logic        i_no_abort_on_stopped_clock,
  input  wire logic        i_permit_strap,
  output logic             o_phy_comm_allowed,
  output logic             o_bus_connected,
  output logic             o_posted_write_on,
  output logic             o_phy_enhance_on,
  output logic             o_soft_reset_busy,
  output logic [31:0]      o_self_id_base
);
  import lhc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic        live_s1_r;
  logic        live_s2_r;
  logic        ack_r;
  logic        abort_r;
  logic [31:0] rdata_r;
  logic        enh_r;
  logic        lps_r;
  logic        pwe_r;
  logic        link_r;
  logic        srst_r;
  logic [3:0]  srst_cnt_r;
  logic        permit_r;
  logic        strap_done_r;
  logic        conn_r;
  logic [31:LHC_SID_LSB] sid_r;
  logic        take;
  logic        wr_set;
  logic        wr_clr;
  logic        wr_sid;
  logic        phy_dom;
  logic [31:0] ctrl_rd;

  ////////////////////////////////////////////////////////////////////////////
  // PHY clock state is a foreign level
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      live_s1_r <= 1'b0;
      live_s2_r <= 1'b0;
    end else begin
      live_s1_r <= i_phy_clk_live;
      live_s2_r <= live_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One take per request; ack blocks the held request from repeating
  assign take   = bus.req & ~ack_r;
  assign wr_set = take & bus.write & (bus.addr == LHC_CTRL_SET_OFS); // [RULE19]
  assign wr_clr = take & bus.write & (bus.addr == LHC_CTRL_CLR_OFS); // [RULE19]
  assign wr_sid = take & bus.write & (bus.addr == LHC_SID_BASE_OFS);
  assign phy_dom = ((bus.addr >= LHC_PHYDOM_A_LO) && (bus.addr <= LHC_PHYDOM_A_HI)) ||
                   ((bus.addr >= LHC_PHYDOM_B_LO) && (bus.addr <= LHC_PHYDOM_B_HI)); // [RULE7]

  always_comb begin
    ctrl_rd                 = 32'h0000_0000; // [RULE3] [RULE15]
    ctrl_rd[LHC_BIT_PERMIT] = permit_r;
    ctrl_rd[LHC_BIT_ENH]    = enh_r;
    ctrl_rd[LHC_BIT_LPS]    = lps_r;
    ctrl_rd[LHC_BIT_PWE]    = pwe_r;
    ctrl_rd[LHC_BIT_LINK]   = link_r;
    ctrl_rd[LHC_BIT_SRST]   = srst_r; // [RULE14]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap caught after release; software reset never reaches it
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      permit_r     <= 1'b0; // [RULE16]
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      permit_r     <= i_permit_strap;
      strap_done_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software reset sequencer
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      srst_r     <= 1'b0;
      srst_cnt_r <= 4'h0;
    end else if (srst_r) begin
      srst_cnt_r <= srst_cnt_r - 4'h1;
      if (srst_cnt_r == 4'h0) begin
        srst_r <= 1'b0; // [RULE14]
      end
    end else if (wr_set && bus.wdata[LHC_BIT_SRST]) begin
      srst_r     <= 1'b1;
      srst_cnt_r <= LHC_SRST_CYCLES - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits; while software reset runs they sit at reset values
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      enh_r  <= 1'b0;
      lps_r  <= 1'b0;
      pwe_r  <= 1'b0;
      link_r <= 1'b0; // [RULE10]
    end else if (srst_r) begin
      enh_r  <= 1'b0; // [RULE13]
      lps_r  <= 1'b0;
      pwe_r  <= 1'b0;
      link_r <= 1'b0; // [RULE10]
    end else if (wr_set) begin
      if (bus.wdata[LHC_BIT_ENH] && permit_r && link_r) begin
        enh_r <= 1'b1; // [RULE1] [RULE20]
      end
      if (bus.wdata[LHC_BIT_LPS]) begin
        lps_r <= 1'b1; // [RULE20]
      end
      if (bus.wdata[LHC_BIT_PWE] && !link_r) begin
        pwe_r <= 1'b1; // [RULE9]
      end
      if (bus.wdata[LHC_BIT_LINK]) begin
        link_r <= 1'b1;
      end
    end else if (wr_clr) begin
      if (bus.wdata[LHC_BIT_ENH] && permit_r) begin
        enh_r <= 1'b0; // [RULE2] [RULE20]
      end
      if (bus.wdata[LHC_BIT_LPS]) begin
        lps_r <= 1'b0;
      end
      if (bus.wdata[LHC_BIT_PWE] && !link_r) begin
        pwe_r <= 1'b0; // [RULE9]
      end
      if (bus.wdata[LHC_BIT_LINK]) begin
        link_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-ID base: only the 2K-aligned upper bits are stored
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sid_r <= LHC_SID_RST[31:LHC_SID_LSB];
    end else if (srst_r) begin
      sid_r <= LHC_SID_RST[31:LHC_SID_LSB]; // [RULE13]
    end else if (wr_sid) begin
      sid_r <= bus.wdata[31:LHC_SID_LSB]; // [RULE17] [RULE18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus connection drops in the same cycle that link goes off
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      conn_r <= 1'b0;
    end else begin
      conn_r <= link_r & ~srst_r & ~(wr_clr & bus.wdata[LHC_BIT_LINK]); // [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer one cycle after the take
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_r   <= 1'b0;
      abort_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= take;
      abort_r <= 1'b0;
      if (take) begin
        if (phy_dom && !live_s2_r) begin
          if (i_no_abort_on_stopped_clock) begin
            rdata_r <= LHC_ALL_ONES; // [RULE6]
          end else begin
            abort_r <= 1'b1; // [RULE5]
            rdata_r <= 32'h0000_0000;
          end
        end else if (bus.write) begin
          rdata_r <= 32'h0000_0000;
        end else if ((bus.addr == LHC_CTRL_SET_OFS) || (bus.addr == LHC_CTRL_CLR_OFS)) begin
          rdata_r <= ctrl_rd; // [RULE20]
        end else if (bus.addr == LHC_SID_BASE_OFS) begin
          rdata_r <= {sid_r, 11'h000}; // [RULE18]
        end else begin
          // Unmodelled addresses read zero
          rdata_r <= 32'h0000_0000;
        end
      end
    end
  end

  assign bus.ack            = ack_r;
  assign bus.abort          = abort_r;
  assign bus.rdata          = rdata_r;
  assign o_phy_comm_allowed = lps_r; // [RULE4]
  assign o_bus_connected    = conn_r;
  assign o_posted_write_on  = pwe_r;
  assign o_phy_enhance_on   = enh_r;
  assign o_soft_reset_busy  = srst_r;
  assign o_self_id_base     = {sid_r, 11'h000};
endmodule : lhc_dev

// ===== rtl/lhc_host.sv
/*
 Controller end: takes orders from software over AHB-Lite and issues
 single register accesses on the link to the register bank.
 Assumes a single AHB-Lite master and zero-wait answers from this slave.
*/
`timescale 1ns/1ns
module lhc_host
  import lhc_pkg::*;
#(
  parameter int LPS_WAIT_CYC = LHC_LPS_WAIT_CYC
)(
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  lhc_if.host              lnk
);
  import lhc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  lhc_hstate_t state_r;
  logic [11:0] addr_r;
  logic [31:0] wdata_r;
  logic        write_r;
  logic        req_r;
  logic [31:0] rdata_r;
  logic        aborted_r;
  logic [31:0] wait_r;
  logic        dwr_r;
  logic [4:0]  daddr_r;
  logic [31:0] hrdata_r;
  logic        aphase;
  logic        go;

  assign aphase = i_hsel & i_hready & i_htrans[1];
  assign go     = dwr_r & (daddr_r == LHC_H_CMD_OFS) & i_hwdata[LHC_CMD_GO];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait, read data registered at the address phase
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dwr_r    <= 1'b0;
      daddr_r  <= 5'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      dwr_r   <= aphase & i_hwrite;
      daddr_r <= i_haddr[4:0];
      if (aphase && !i_hwrite) begin
        case (i_haddr[4:0])
          LHC_H_ADDR_OFS:  hrdata_r <= {20'h00000, addr_r};
          LHC_H_WDATA_OFS: hrdata_r <= wdata_r;
          LHC_H_CMD_OFS:   hrdata_r <= {30'h0, write_r, 1'b0};
          LHC_H_STAT_OFS:  hrdata_r <= {29'h0, state_r == LHC_HS_LPSW, aborted_r,
                                        state_r != LHC_HS_IDLE};
          LHC_H_RDATA_OFS: hrdata_r <= rdata_r;
          default:         hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Order fields are frozen while a request is out
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_r  <= 12'h000;
      wdata_r <= 32'h0000_0000;
      write_r <= 1'b0;
    end else if (dwr_r && state_r == LHC_HS_IDLE) begin
      if (daddr_r == LHC_H_ADDR_OFS) begin
        addr_r <= i_hwdata[11:0];
      end
      if (daddr_r == LHC_H_WDATA_OFS) begin
        wdata_r <= i_hwdata;
      end
      if (daddr_r == LHC_H_CMD_OFS) begin
        write_r <= i_hwdata[LHC_CMD_WRITE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request sequencer; go while busy is dropped
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r   <= LHC_HS_IDLE;
      req_r     <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      aborted_r <= 1'b0;
      wait_r    <= 32'h0000_0000;
    end else begin
      case (state_r)
        LHC_HS_IDLE: begin
          if (go) begin
            req_r     <= 1'b1;
            aborted_r <= 1'b0;
            state_r   <= LHC_HS_REQ;
          end
        end
        LHC_HS_REQ: begin
          if (lnk.ack) begin
            req_r     <= 1'b0;
            rdata_r   <= lnk.rdata;
            aborted_r <= lnk.abort; // [RULE5]
            if (write_r && addr_r == LHC_CTRL_SET_OFS && wdata_r[LHC_BIT_LPS]) begin
              wait_r  <= 32'(LPS_WAIT_CYC - 1); // [RULE8]
              state_r <= LHC_HS_LPSW;
            end else begin
              state_r <= LHC_HS_IDLE;
            end
          end
        end
        LHC_HS_LPSW: begin
          // PHY clock settles before any further access
          wait_r <= wait_r - 32'h1;
          if (wait_r == 32'h0) begin
            state_r <= LHC_HS_IDLE; // [RULE8]
          end
        end
        default: state_r <= LHC_HS_IDLE;
      endcase
    end
  end

  assign lnk.req     = req_r;
  assign lnk.write   = write_r;
  assign lnk.addr    = addr_r;
  assign lnk.wdata   = wdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = hrdata_r;
endmodule : lhc_host

// ===== rtl/lhc_if.sv
/*
 Register access link between the controller (host) and the register bank (dev).
 Assumes both ends run on the same clock; the host holds req until ack.
*/
`timescale 1ns/1ns
interface lhc_if;
  logic        req;
  logic        write;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        ack;
  logic        abort;
  logic [31:0] rdata;

  modport dev  (input req, write, addr, wdata, output ack, abort, rdata);
  modport host (output req, write, addr, wdata, input ack, abort, rdata);
endinterface : lhc_if

// ===== rtl/lhc_pkg.sv
/*
 Shared constants of the link host control register bank and its controller.
 Assumes a single 50 MHz clock for both ends.
*/
package lhc_pkg;
  // Device register map (byte addresses)
  localparam logic [11:0] LHC_CTRL_SET_OFS  = 12'h050;
  localparam logic [11:0] LHC_CTRL_CLR_OFS  = 12'h054;
  localparam logic [11:0] LHC_SID_BASE_OFS  = 12'h064;
  localparam logic [11:0] LHC_PHYDOM_A_LO   = 12'h0dc;
  localparam logic [11:0] LHC_PHYDOM_A_HI   = 12'h0f0;
  localparam logic [11:0] LHC_PHYDOM_B_LO   = 12'h100;
  localparam logic [11:0] LHC_PHYDOM_B_HI   = 12'h11c;
  // Control register bit positions
  localparam int LHC_BIT_PERMIT = 23;
  localparam int LHC_BIT_ENH    = 22;
  localparam int LHC_BIT_LPS    = 19;
  localparam int LHC_BIT_PWE    = 18;
  localparam int LHC_BIT_LINK   = 17;
  localparam int LHC_BIT_SRST   = 16;
  localparam int LHC_SID_LSB    = 11;
  // Reset values
  localparam logic [31:0] LHC_SID_RST  = 32'h0000_0000;
  localparam logic [31:0] LHC_ALL_ONES = 32'hffff_ffff;
  // Timing
  localparam int LHC_CLK_MHZ      = 50;
  localparam logic [3:0] LHC_SRST_CYCLES = 4'h8;
  localparam int LHC_LPS_WAIT_US  = 10000;
  localparam int LHC_LPS_WAIT_CYC = LHC_LPS_WAIT_US * LHC_CLK_MHZ;
  // Controller registers on AHB-Lite (byte addresses)
  localparam logic [4:0] LHC_H_ADDR_OFS  = 5'h00;
  localparam logic [4:0] LHC_H_WDATA_OFS = 5'h04;
  localparam logic [4:0] LHC_H_CMD_OFS   = 5'h08;
  localparam logic [4:0] LHC_H_STAT_OFS  = 5'h0c;
  localparam logic [4:0] LHC_H_RDATA_OFS = 5'h10;
  localparam int LHC_CMD_GO    = 0;
  localparam int LHC_CMD_WRITE = 1;

  typedef enum logic [1:0] {
    LHC_HS_IDLE = 2'b00,
    LHC_HS_REQ  = 2'b01,
    LHC_HS_LPSW = 2'b10
  } lhc_hstate_t;
endpackage : lhc_pkg

// ===== sim/lhc_asserts.sv
/*
 Checker for the link between controller and register bank.
 Assumes one clock; the bench instantiates it beside the link.
*/
`timescale 1ns/1ns
module lhc_asserts (
  input wire logic        i_mclk,
  input wire logic        i_resetn,
  input wire logic        req,
  input wire logic        write,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic        abort,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic ctl_rd;
  logic phy_dom;
  assign ctl_rd  = ack && !write && !abort && (addr == 12'h050 || addr == 12'h054);
  assign phy_dom = (addr >= 12'h0dc && addr <= 12'h0f0) || (addr >= 12'h100 && addr <= 12'h11c);
  ////////////////////////////////////////////////////////////////////////////
  property p_ack_next; req && !ack |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("answer late");
  property p_ack_pulse; ack |=> !ack && !req; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer not a pulse");
  property p_req_hold; req && !ack |=> req && $stable(addr) && $stable(write) && $stable(wdata); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  property p_abort; abort |-> ack && phy_dom && rdata == 32'h0; endproperty
  a_abort: assert property (p_abort) else $error("bad abort");
  property p_ctl_low; ctl_rd |-> rdata[15:0] == 16'h0; endproperty
  a_ctl_low: assert property (p_ctl_low) else $error("low bits set");
  property p_ctl_rsvd; ctl_rd |-> rdata[21:20] == 2'h0; endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("bits 21:20 set");
  property p_sid_low; ack && !write && addr == 12'h064 |-> rdata[10:0] == 11'h0; endproperty
  a_sid_low: assert property (p_sid_low) else $error("base low bits set");
  property p_rd_hold; !ack |-> $stable(rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // Permit only falls with global reset, which also clears enhancements
  property p_enh_permit; ctl_rd && rdata[22] |-> rdata[23]; endproperty
  a_enh_permit: assert property (p_enh_permit) else $error("enhance without permit");
  c_abort: cover property (abort);
  c_ones: cover property (ack && !abort && rdata == 32'hffff_ffff);
  c_enh: cover property (ctl_rd && rdata[22]);
endmodule : lhc_asserts

// ===== sim/link_host_control_regs_tb_top.sv
/*
 Bench for controller and register bank joined by the link.
 Assumes zero-wait AHB-Lite answers and a 20-cycle power-status wait.
*/
`timescale 1ns/1ns
module link_host_control_regs_tb_top;
  import lhc_pkg::*;
  logic        i_mclk   = 1'b0;
  logic        i_resetn = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic        live     = 1'b1;
  logic        noab     = 1'b0;
  logic        strap    = 1'b1;
  logic        hready, hresp, comm, conn, pwe, enh, srst;
  logic [31:0] hrdata, sid;
  int          err_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  int          srst_cnt  = 0;
  int          lps_polls = 0;
  lhc_if lnk ();
  always #10 i_mclk = ~i_mclk;
  lhc_host #(.LPS_WAIT_CYC(20)) lhc_host_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .lnk(lnk));
  lhc_dev lhc_dev_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .bus(lnk), .i_phy_clk_live(live),
    .i_no_abort_on_stopped_clock(noab), .i_permit_strap(strap), .o_phy_comm_allowed(comm),
    .o_bus_connected(conn), .o_posted_write_on(pwe), .o_phy_enhance_on(enh),
    .o_soft_reset_busy(srst), .o_self_id_base(sid));
  lhc_asserts lhc_asserts_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .req(lnk.req), .write(lnk.write),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .abort(lnk.abort), .rdata(lnk.rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge i_mclk) begin
    cyc++;
    if (srst === 1'b1) srst_cnt++;
    if (cyc == 8000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  // One single transfer; entered right after a rising edge
  task automatic ahb(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {27'h0, a};
    hwrite <= wr;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    q = hrdata;
  endtask : ahb
  task automatic lop(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic ab);
    logic [31:0] s;
    ahb(1'b1, LHC_H_ADDR_OFS, {20'h0, a}, s);
    ahb(1'b1, LHC_H_WDATA_OFS, d, s);
    ahb(1'b1, LHC_H_CMD_OFS, {30'h0, wr, 1'b1}, s);
    s = 32'h1;
    while (s[0] !== 1'b0) begin
      ahb(1'b0, LHC_H_STAT_OFS, 32'h0, s);
      if (s[2] === 1'b1) lps_polls++;
    end
    ab = s[1];
    ahb(1'b0, LHC_H_RDATA_OFS, 32'h0, q);
  endtask : lop
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        ab;
    lop(1'b1, a, d, q, ab);
  endtask : wreg
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eab);
    logic [31:0] q;
    logic        ab;
    lop(1'b0, a, 32'h0, q, ab);
    chk(q, exp);
    chk({31'h0, ab}, {31'h0, eab});
  endtask : rchk
  task automatic outs(input logic [4:0] exp);
    chk({27'h0, comm, conn, pwe, enh, srst}, {27'h0, exp});
  endtask : outs
  task automatic do_reset(input logic s);
    strap    <= s;
    i_resetn <= 1'b0;
    repeat (12) @(posedge i_mclk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    rchk(12'h050, 32'h0080_0000, 1'b0);
    rchk(12'h054, 32'h0080_0000, 1'b0);
    outs(5'h00);
  endtask : t_reset_vals
  task automatic t_sid;
    wreg(12'h064, 32'hffff_ffff);
    rchk(12'h064, 32'hffff_f800, 1'b0);
    chk(sid, 32'hffff_f800);
  endtask : t_sid
  task automatic t_ctrl;
    wreg(12'h050, 32'h0004_0000);
    rchk(12'h054, 32'h0084_0000, 1'b0);
    wreg(12'h050, 32'h0032_0000);
    rchk(12'h050, 32'h0086_0000, 1'b0);
    outs(5'h0c);
    wreg(12'h054, 32'h0004_0000);
    rchk(12'h050, 32'h0086_0000, 1'b0);
    lps_polls = 0;
    wreg(12'h050, 32'h0048_0000);
    // Two-cycle polls across the 20-cycle settle wait
    chk(lps_polls, 32'd10);
    rchk(12'h050, 32'h00ce_0000, 1'b0);
    outs(5'h1e);
    wreg(12'h054, 32'h0002_0000);
    rchk(12'h050, 32'h00cc_0000, 1'b0);
    outs(5'h16);
  endtask : t_ctrl
  task automatic t_soft_reset;
    wreg(12'h050, 32'h0002_0000);
    srst_cnt = 0;
    wreg(12'h050, 32'h0001_0000);
    repeat (12) @(posedge i_mclk);
    chk(srst_cnt, 32'd8);
    rchk(12'h050, 32'h0080_0000, 1'b0);
    rchk(12'h064, 32'h0, 1'b0);
    outs(5'h00);
  endtask : t_soft_reset
  // Both enhancement conditions refused one at a time
  task automatic t_permit;
    do_reset(1'b0);
    wreg(12'h050, 32'h0002_0000);
    wreg(12'h050, 32'h0040_0000);
    rchk(12'h050, 32'h0002_0000, 1'b0);
    do_reset(1'b1);
    wreg(12'h050, 32'h0040_0000);
    rchk(12'h050, 32'h0080_0000, 1'b0);
  endtask : t_permit
  task automatic t_phy;
    live <= 1'b0;
    rchk(12'h0dc, 32'h0, 1'b1);
    rchk(12'h11c, 32'h0, 1'b1);
    rchk(12'h0d8, 32'h0, 1'b0);
    noab <= 1'b1;
    rchk(12'h0f0, 32'hffff_ffff, 1'b0);
    rchk(12'h100, 32'hffff_ffff, 1'b0);
    live <= 1'b1;
    noab <= 1'b0;
    rchk(12'h0dc, 32'h0, 1'b0);
  endtask : t_phy
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b1);
    t_reset_vals();
    t_sid();
    t_ctrl();
    t_soft_reset();
    t_permit();
    t_phy();
    give_verdict();
  end
endmodule : link_host_control_regs_tb_top
